// File: hw/dtm_ctrl.sv
// control logic of the two-channel temperature monitor with avalon-mm registers
`timescale 1ns/100ps
module dtm_ctrl #(
	parameter int unsigned INTEG_CYCLES = 32'(dtm_pkg::INTEG_CYC),
	parameter int unsigned BASE_PERIOD_CYCLES = 32'(dtm_pkg::BASE_PERIOD_CYC)
) (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	// avalon-mm slave
	input wire logic [5:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// pins, asynchronous to the clock
	input wire logic RESET_PIN_I,
	input wire logic HW_STANDBY_N_I,
	input wire logic INT_SEL_I,
	input wire logic [1:0] ALARM_SOURCE_SELECT_I,
	input wire logic ADDR_SELECT_LO_I,
	input wire logic ADDR_SELECT_HI_I,
	input wire logic DEFAULT_LIMIT_STRAP_LO_I,
	input wire logic DEFAULT_LIMIT_STRAP_HI_I,
	// open-drain alarms
	output logic OVERTEMP_ALARM_N_O,
	output logic OVERTEMP_ALARM_N_OE_O,
	output logic ALERT_N_O,
	output logic ALERT_N_OE_O,
	// converter front end, same clock
	input wire logic [10:0] ADC_DATA_I,
	output logic ADC_CONV_O,
	output logic ADC_CHAN_O,
	output logic ADC_SENSOR_TYPE_O,
	output logic [1:0] SLAVE_ADDR_O
);

	// whole module state
	typedef struct packed {
		logic [1:0] rst_s; // reset pin synchroniser
		logic [1:0] hw_standby_n_s; // standby pin synchroniser
		logic [1:0] isel_s; // interrupt-select synchroniser
		logic [1:0] src_a; // source select, first stage
		logic [1:0] src_b; // source select, second stage
		logic [1:0] src_prev; // previous second-stage sample, not decoded
		dtm_pkg::dtm_src_e src_sel; // held source selection
		logic [3:0] strap_a; // straps, first stage
		logic [3:0] strap_b; // straps, second stage
		logic [1:0] boot_cnt; // settle count after reset release
		logic strap_done; // straps latched
		logic [1:0] addr; // latched bus address
		logic [1:0] crit; // latched overtemp strap
		dtm_pkg::dtm_cfg_s cfg; // configuration byte
		logic [2:0] rate; // conversion rate code
		logic [7:0] lhi;
		logic [7:0] llo;
		logic [7:0] rhi;
		logic [7:0] rlo;
		logic [7:0] lovt;
		logic [7:0] rovt;
		logic [3:0] flags; // sticky limit flags
		dtm_pkg::dtm_seq_e seq; // sequencer state
		logic one_shot; // current sequence is a one-shot
		logic [31:0] tmr; // integration timer
		logic [31:0] rate_tmr; // time to next autonomous start
		logic [7:0] loc_sh; // local result awaiting commit
		logic [7:0] loc_t; // visible local result
		logic [10:0] rem_t; // visible remote result
		logic ovt_l; // local overtemp
		logic ovt_r; // remote overtemp
		logic alrt; // alert pulled low
		logic ack; // bus answer cycle
		logic [31:0] rdata; // read data
	} dtm_state_s;

	dtm_state_s r_r;
	dtm_state_s r_nxt;

	// three-level decode of the source select pair
	function automatic dtm_pkg::dtm_src_e dec_src(input logic [1:0] v);
		case (v)
			2'h0: dec_src = dtm_pkg::SRC_LOCAL;
			2'h3: dec_src = dtm_pkg::SRC_REMOTE;
			default: dec_src = dtm_pkg::SRC_BOTH;
		endcase
	endfunction

	// clamp a raw reading to the active floor
	function automatic logic [10:0] clamp(input logic [10:0] v, input logic ext);
		logic [10:0] fl;
		fl = ext ? dtm_pkg::FLOOR_EXT : dtm_pkg::FLOOR_DEF;
		clamp = ($signed(v) < $signed(fl)) ? fl : v;
	endfunction

	logic req; // request pending on the bus
	logic wr_acc; // write takes effect this edge
	logic rd_acc; // read completes this edge
	logic [5:0] word; // word-aligned address
	logic pin_rst; // reset pin asserted
	logic hw_hw_standby_n; // hardware standby
	logic start; // begin a sequence
	logic start_os; // begin as one-shot
	logic [10:0] rem_new; // remote result being committed
	logic [10:0] loc_cl; // local reading after the floor clamp
	logic [3:0] set_f; // flags raised this edge
	logic [3:0] clr_f; // flags cleared by a status read
	logic rem_viol; // remote outside its window
	logic [31:0] period; // autonomous period in cycles
	logic [7:0] ovt_def; // strap default overtemp limit

	// next-state logic
	always_comb begin
		r_nxt = r_r;
		word = {AVS_ADDRESS_I[5:2], 2'h0};
		req = AVS_READ_I | AVS_WRITE_I;
		wr_acc = AVS_WRITE_I & r_r.ack;
		rd_acc = AVS_READ_I & r_r.ack;
		pin_rst = r_r.rst_s[1];
		hw_hw_standby_n = ~r_r.hw_standby_n_s[1];
		start = 1'b0;
		start_os = 1'b0;
		set_f = 4'h0;
		clr_f = 4'h0;
		rem_new = r_r.rem_t;
		// clamp into a variable first, a call result cannot be part-selected
		loc_cl = clamp(ADC_DATA_I, r_r.cfg.ext_range); // RULE_12
		period = BASE_PERIOD_CYCLES >> r_r.rate;
		ovt_def = dtm_pkg::OVT_DEF_TABLE[{r_r.crit, 3'h0} +: 8];

		// two-flop synchronisers
		r_nxt.rst_s = {r_r.rst_s[0], RESET_PIN_I};
		r_nxt.hw_standby_n_s = {r_r.hw_standby_n_s[0], HW_STANDBY_N_I};
		r_nxt.isel_s = {r_r.isel_s[0], INT_SEL_I};
		r_nxt.src_a = ALARM_SOURCE_SELECT_I;
		r_nxt.src_b = r_r.src_a;
		r_nxt.strap_a = {DEFAULT_LIMIT_STRAP_HI_I, DEFAULT_LIMIT_STRAP_LO_I,
			ADDR_SELECT_HI_I, ADDR_SELECT_LO_I};
		r_nxt.strap_b = r_r.strap_a;

		// selection only moves after two equal samples, so a pin in transit
		// between levels never flickers the alarm source
		r_nxt.src_prev = r_r.src_b;
		if (r_r.src_b == r_r.src_prev) begin // RULE_23
			r_nxt.src_sel = dec_src(r_r.src_b); // RULE_09
		end

		// straps caught once, after the synchroniser has filled
		if (!r_r.strap_done) begin
			r_nxt.boot_cnt = r_r.boot_cnt + 2'h1;
			if (r_r.boot_cnt == dtm_pkg::STRAP_SETTLE) begin
				r_nxt.strap_done = 1'b1; // RULE_20
				r_nxt.addr = r_r.strap_b[1:0]; // RULE_20
				r_nxt.crit = r_r.strap_b[3:2];
				r_nxt.lovt = dtm_pkg::OVT_DEF_TABLE[{r_r.strap_b[3:2], 3'h0} +: 8];
				r_nxt.rovt = dtm_pkg::OVT_DEF_TABLE[{r_r.strap_b[3:2], 3'h0} +: 8];
			end
		end

		// bus: one wait cycle, then the answer edge
		r_nxt.ack = req & ~r_r.ack;
		if (req && !r_r.ack) begin
			case (word)
				dtm_pkg::REG_CONFIG: r_nxt.rdata = {24'h0, r_r.cfg};
				dtm_pkg::REG_RATE: r_nxt.rdata = {29'h0, r_r.rate};
				dtm_pkg::REG_STATUS: r_nxt.rdata = {24'h0, (r_r.seq != dtm_pkg::SQ_IDLE),
					r_r.flags, 1'b0, r_r.ovt_l, r_r.ovt_r}; // RULE_17
				dtm_pkg::REG_LOC_TEMP: r_nxt.rdata = {24'h0, r_r.loc_t}; // RULE_18
				dtm_pkg::REG_REM_TEMP: r_nxt.rdata = {21'h0, r_r.rem_t}; // RULE_18
				dtm_pkg::REG_LOC_HIGH: r_nxt.rdata = {24'h0, r_r.lhi};
				dtm_pkg::REG_LOC_LOW: r_nxt.rdata = {24'h0, r_r.llo};
				dtm_pkg::REG_REM_HIGH: r_nxt.rdata = {24'h0, r_r.rhi};
				dtm_pkg::REG_REM_LOW: r_nxt.rdata = {24'h0, r_r.rlo};
				dtm_pkg::REG_LOC_OVT: r_nxt.rdata = {24'h0, r_r.lovt};
				dtm_pkg::REG_REM_OVT: r_nxt.rdata = {24'h0, r_r.rovt};
				dtm_pkg::REG_ADDR: r_nxt.rdata = {30'h0, r_r.addr};
				default: r_nxt.rdata = 32'h0; // unmapped reads zero
			endcase
		end

		// status read clears the sticky flags
		if (rd_acc && word == dtm_pkg::REG_STATUS) begin
			clr_f = 4'hF;
		end

		// register writes, low byte lane only
		if (wr_acc && AVS_BYTEENABLE_I[0]) begin
			case (word)
				dtm_pkg::REG_CONFIG: r_nxt.cfg = AVS_WRITEDATA_I[7:0]; // RULE_13 RULE_19 RULE_21
				dtm_pkg::REG_RATE: r_nxt.rate = AVS_WRITEDATA_I[2:0];
				dtm_pkg::REG_ONESHOT: start_os = ~hw_hw_standby_n; // RULE_22
				dtm_pkg::REG_LOC_HIGH: r_nxt.lhi = AVS_WRITEDATA_I[7:0];
				dtm_pkg::REG_LOC_LOW: r_nxt.llo = AVS_WRITEDATA_I[7:0];
				dtm_pkg::REG_REM_HIGH: r_nxt.rhi = AVS_WRITEDATA_I[7:0];
				dtm_pkg::REG_REM_LOW: r_nxt.rlo = AVS_WRITEDATA_I[7:0];
				dtm_pkg::REG_LOC_OVT: r_nxt.lovt = AVS_WRITEDATA_I[7:0];
				dtm_pkg::REG_REM_OVT: r_nxt.rovt = AVS_WRITEDATA_I[7:0];
				default: ; // read-only or unmapped: write dropped
			endcase
		end

		// autonomous rate timer counts down to zero and holds; autonomous starts happen only outside both standbys, one-shot starts outside hardware standby
		if (r_r.rate_tmr != 32'h0) begin
			r_nxt.rate_tmr = r_r.rate_tmr - 32'h1;
		end
		if (r_r.seq == dtm_pkg::SQ_IDLE) begin
			if (start_os) begin
				start = 1'b1; // RULE_16 RULE_22
			end else if (!hw_hw_standby_n && !r_r.cfg.run_stop && r_r.rate_tmr == 32'h0) begin
				start = 1'b1; // RULE_16 RULE_21
			end
		end

		// conversion sequencer: local first, then remote, always both
		case (r_r.seq)
			dtm_pkg::SQ_IDLE: begin
				if (start) begin
					r_nxt.seq = dtm_pkg::SQ_LOCAL; // RULE_15 RULE_17
					r_nxt.one_shot = start_os;
					r_nxt.tmr = INTEG_CYCLES - 32'h1; // RULE_14
					r_nxt.rate_tmr = period - 32'h1;
				end
			end
			dtm_pkg::SQ_LOCAL: begin
				if (r_r.tmr == 32'h0) begin
					// legacy format: sign and seven integer bits
					r_nxt.loc_sh = loc_cl[10:3]; // RULE_10 RULE_12
					r_nxt.seq = dtm_pkg::SQ_REMOTE; // RULE_15
					r_nxt.tmr = INTEG_CYCLES - 32'h1; // RULE_14
				end else begin
					r_nxt.tmr = r_r.tmr - 32'h1;
				end
			end
			dtm_pkg::SQ_REMOTE: begin
				if (r_r.tmr == 32'h0) begin
					rem_new = clamp(ADC_DATA_I, r_r.cfg.ext_range); // RULE_12 RULE_13
					// fraction kept only when slow enough or single-shot
					if (!(r_r.cfg.ext_res && (r_r.one_shot
							|| r_r.rate <= dtm_pkg::RATE_EXT_MAX))) begin // RULE_11 RULE_24
						rem_new[2:0] = 3'h0; // RULE_10
					end
					// both results become visible together
					r_nxt.loc_t = r_r.loc_sh; // RULE_18
					r_nxt.rem_t = rem_new; // RULE_18
					set_f[3] = $signed(r_r.loc_sh) > $signed(r_r.lhi);
					set_f[2] = $signed(r_r.loc_sh) < $signed(r_r.llo);
					set_f[1] = $signed(rem_new[10:3]) > $signed(r_r.rhi);
					set_f[0] = $signed(rem_new[10:3]) < $signed(r_r.rlo);
					// overtemp from the committed results
					r_nxt.ovt_l = $signed(r_r.loc_sh) > $signed(r_r.lovt); // RULE_03
					r_nxt.ovt_r = $signed(rem_new[10:3]) > $signed(r_r.rovt); // RULE_03
					r_nxt.seq = dtm_pkg::SQ_IDLE; // RULE_17
				end else begin
					r_nxt.tmr = r_r.tmr - 32'h1;
				end
			end
			default: r_nxt.seq = dtm_pkg::SQ_IDLE;
		endcase

		// hardware standby aborts a running sequence; old results stay
		if (hw_hw_standby_n && r_r.seq != dtm_pkg::SQ_IDLE) begin
			r_nxt.seq = dtm_pkg::SQ_IDLE; // RULE_08
			r_nxt.rate_tmr = 32'h0;
		end

		// set beats clear for the same edge
		r_nxt.flags = (r_r.flags & ~clr_f) | set_f;

		// alert: comparator on the remote window, or latched flags
		rem_viol = ($signed(r_r.rem_t[10:3]) > $signed(r_r.rhi))
			| ($signed(r_r.rem_t[10:3]) < $signed(r_r.rlo));
		if (!r_r.isel_s[1]) begin
			// stays low until back in limits and the mask allows release
			if (rem_viol) begin
				r_nxt.alrt = 1'b1; // RULE_06
			end else if (r_r.cfg.alert_mask) begin
				r_nxt.alrt = 1'b0; // RULE_07
			end
		end else begin
			r_nxt.alrt = (|r_nxt.flags) & ~r_r.cfg.alert_mask; // RULE_05
		end

		// reset pin: all registers back to defaults, straps kept
		if (pin_rst) begin
			r_nxt.cfg = dtm_pkg::CONFIG_RST; // RULE_01
			r_nxt.rate = dtm_pkg::RATE_RST; // RULE_01
			r_nxt.lhi = dtm_pkg::HIGH_RST;
			r_nxt.llo = dtm_pkg::LOW_RST;
			r_nxt.rhi = dtm_pkg::HIGH_RST;
			r_nxt.rlo = dtm_pkg::LOW_RST;
			r_nxt.lovt = ovt_def; // RULE_01
			r_nxt.rovt = ovt_def;
			r_nxt.flags = 4'h0;
			r_nxt.seq = dtm_pkg::SQ_IDLE;
			r_nxt.rate_tmr = 32'h0;
			r_nxt.loc_t = 8'h0;
			r_nxt.rem_t = dtm_pkg::TEMP_RST;
			r_nxt.ovt_l = 1'b0;
			r_nxt.ovt_r = 1'b0;
			r_nxt.alrt = 1'b0;
		end
	end

	// state register; async reset loads constants only
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			r_r <= '0;
			r_r.src_sel <= dtm_pkg::SRC_BOTH;
			r_r.hw_standby_n_s <= 2'h3;
			r_r.isel_s <= 2'h3;
			r_r.cfg <= dtm_pkg::CONFIG_RST;
			r_r.rate <= dtm_pkg::RATE_RST;
			r_r.lhi <= dtm_pkg::HIGH_RST;
			r_r.llo <= dtm_pkg::LOW_RST;
			r_r.rhi <= dtm_pkg::HIGH_RST;
			r_r.rlo <= dtm_pkg::LOW_RST;
			r_r.lovt <= dtm_pkg::OVT_DEF_TABLE[7:0];
			r_r.rovt <= dtm_pkg::OVT_DEF_TABLE[7:0];
			r_r.seq <= dtm_pkg::SQ_IDLE;
		end else begin
			r_r <= r_nxt;
		end
	end

	// bus outputs: waitrequest is combinational, data registered
	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~r_r.ack;
	assign AVS_READDATA_O = r_r.rdata;

	// open drain: only ever drive low, enable while asserted
	assign OVERTEMP_ALARM_N_O = 1'b0; // RULE_02
	assign OVERTEMP_ALARM_N_OE_O = (r_r.src_sel == dtm_pkg::SRC_LOCAL) ? r_r.ovt_l
		: (r_r.src_sel == dtm_pkg::SRC_REMOTE) ? r_r.ovt_r
		: (r_r.ovt_l | r_r.ovt_r); // RULE_02 RULE_09
	assign ALERT_N_O = 1'b0; // RULE_04
	assign ALERT_N_OE_O = r_r.alrt; // RULE_04

	// converter steering
	assign ADC_CONV_O = (r_r.seq != dtm_pkg::SQ_IDLE);
	assign ADC_CHAN_O = (r_r.seq == dtm_pkg::SQ_REMOTE);
	assign ADC_SENSOR_TYPE_O = r_r.cfg.sens_type; // RULE_19
	assign SLAVE_ADDR_O = r_r.addr;

endmodule // dtm_ctrl

// File: hw/dtm_pkg.sv
// constants, register map and shared types of the two-channel temperature monitor
//
// Overview of operation
// (RULE_01) reset pin high restores every register default
// (RULE_02) overtemp alarm is active-low open drain
// (RULE_03) overtemp alarm when temperature exceeds its limit
// (RULE_04) alert output is active-low open drain
// (RULE_05) interrupt-select high: standard latched alert behaviour
// (RULE_06) interrupt-select low: comparator alert on remote
// (RULE_07) comparator alert clears in limits, mask permitting
// (RULE_08) hardware standby stops conversions, keeps registers
// (RULE_09) source select: high remote, low local, open both
// (RULE_10) legacy result is sign plus seven bits
// (RULE_11) extended remote resolution only slow or one-shot
// (RULE_12) readings clamp at zero degrees by default
// (RULE_13) configuration bit 3 extends range to -64
// (RULE_14) each channel integrates for 60 ms
// (RULE_15) sequence converts local then remote, always both
// (RULE_16) auto conversions while run/stop zero, plus one-shot
// (RULE_17) busy flag set for the whole sequence
// (RULE_18) results update only after both channels finish
// (RULE_19) configuration bit 5 selects remote sensor type
// (RULE_20) address select pins latched once after power-up
// (RULE_21) run/stop one enters software standby
// (RULE_22) one-shot ignored in hardware, honoured in software standby
// (RULE_23) three-level source select decoded and held stable
// (RULE_24) above 4 Hz remote reported in legacy format
package dtm_pkg;

	// byte offsets of the register words
	localparam logic [5:0] REG_CONFIG = 6'h00;
	localparam logic [5:0] REG_RATE = 6'h04;
	localparam logic [5:0] REG_ONESHOT = 6'h08;
	localparam logic [5:0] REG_STATUS = 6'h0C;
	localparam logic [5:0] REG_LOC_TEMP = 6'h10;
	localparam logic [5:0] REG_REM_TEMP = 6'h14;
	localparam logic [5:0] REG_LOC_HIGH = 6'h18;
	localparam logic [5:0] REG_LOC_LOW = 6'h1C;
	localparam logic [5:0] REG_REM_HIGH = 6'h20;
	localparam logic [5:0] REG_REM_LOW = 6'h24;
	localparam logic [5:0] REG_LOC_OVT = 6'h28;
	localparam logic [5:0] REG_REM_OVT = 6'h2C;
	localparam logic [5:0] REG_ADDR = 6'h30;

	// status field positions
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_FLAG_LSB = 3;
	localparam int ST_LOVT_BIT = 1;
	localparam int ST_ROVT_BIT = 0;

	// reset values
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [2:0] RATE_RST = 3'h5;
	localparam logic [7:0] HIGH_RST = 8'h46;
	localparam logic [7:0] LOW_RST = 8'h00;
	localparam logic [10:0] TEMP_RST = 11'h000;
	// strap-selected overtemp defaults, index {strap_hi, strap_lo}
	localparam logic [31:0] OVT_DEF_TABLE = 32'h6E645A50;

	// conversion rate codes: code k gives 2^k/16 Hz
	localparam logic [2:0] RATE_EXT_MAX = 3'h6;
	// clamp floors in eighths of a degree
	localparam logic [10:0] FLOOR_DEF = 11'h000;
	localparam logic [10:0] FLOOR_EXT = 11'h600;

	// timing
	localparam longint CLK_HZ = 100000000;
	localparam longint INTEG_MS = 60;
	localparam longint INTEG_CYC = INTEG_MS * CLK_HZ / 1000;
	localparam longint BASE_PERIOD_MS = 16000;
	localparam longint BASE_PERIOD_CYC = BASE_PERIOD_MS * CLK_HZ / 1000;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// configuration byte layout
	typedef struct packed {
		logic alert_mask; // bit 7
		logic run_stop; // bit 6
		logic sens_type; // bit 5
		logic rsvd4;
		logic ext_range; // bit 3
		logic ext_res; // bit 2
		logic [1:0] rsvd;
	} dtm_cfg_s;

	// decoded overtemp source
	typedef enum logic [1:0] {SRC_LOCAL, SRC_REMOTE, SRC_BOTH} dtm_src_e;

	// conversion sequencer
	typedef enum logic [1:0] {SQ_IDLE, SQ_LOCAL, SQ_REMOTE} dtm_seq_e;

endpackage

// File: sim/dtm_ctrl_sva.sv
// port-level checks of the temperature monitor control block
`timescale 1ns/100ps
module dtm_ctrl_sva #(
	parameter int unsigned INTEG_CYCLES = 20,
	parameter int unsigned BASE_PERIOD_CYCLES = 8192
) (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic RESET_PIN_I,
	input wire logic HW_STANDBY_N_I,
	input wire logic OVERTEMP_ALARM_N_O,
	input wire logic OVERTEMP_ALARM_N_OE_O,
	input wire logic ALERT_N_O,
	input wire logic ALERT_N_OE_O,
	input wire logic ADC_CONV_O,
	input wire logic ADC_CHAN_O,
	input wire logic [1:0] SLAVE_ADDR_O
);
	int phase_r; // cycles on the current channel
	int boot_r; // edges since reset release, stops at 8
	logic chan_r; // channel at the previous edge
	logic [3:0] calm_r; // history of pins that may abort a sequence
	logic calm; // no abort can have cut the sequence short
	logic len_ok; // two ticks of slack below, one above, the sampling edge is ours to guess
	assign calm = &calm_r && HW_STANDBY_N_I && !RESET_PIN_I;
	assign len_ok = phase_r >= int'(INTEG_CYCLES) - 2 && phase_r <= int'(INTEG_CYCLES) + 1;
	// helper counters
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			phase_r <= 0;
			boot_r <= 0;
			chan_r <= 1'b0;
			calm_r <= 4'h0;
		end else begin
			phase_r <= (ADC_CONV_O && chan_r == ADC_CHAN_O) ? phase_r + 1 : 0;
			boot_r <= (boot_r < 8) ? boot_r + 1 : 8;
			chan_r <= ADC_CHAN_O;
			calm_r <= {calm_r[2:0], HW_STANDBY_N_I && !RESET_PIN_I};
		end
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
	// local phase over, remote begins
	sequence seq_local_done;
		ADC_CONV_O ##0 $rose(ADC_CHAN_O);
	endsequence
	chk_ovt_drain: assert property (OVERTEMP_ALARM_N_O == 1'b0)
		else $error("overtemp line driven high");
	chk_alert_drain: assert property (ALERT_N_O == 1'b0)
		else $error("alert line driven high");
	chk_start_local: assert property ($rose(ADC_CONV_O) |-> !ADC_CHAN_O)
		else $error("sequence did not start on local");
	chk_local_len: assert property (seq_local_done |-> len_ok)
		else $error("local phase length wrong");
	chk_end_remote: assert property ($fell(ADC_CONV_O) && calm |-> $past(ADC_CHAN_O) && len_ok)
		else $error("sequence ended without full remote phase");
	chk_hw_standby_n_idle: assert property ((!HW_STANDBY_N_I)[*5] |-> !ADC_CONV_O)
		else $error("converting in hardware standby");
	chk_reset_idle: assert property (RESET_PIN_I[*5] |->
		!ADC_CONV_O && !ALERT_N_OE_O && !OVERTEMP_ALARM_N_OE_O)
		else $error("reset pin left state active");
	chk_addr_hold: assert property (boot_r == 8 |-> $stable(SLAVE_ADDR_O))
		else $error("bus address changed after latch");
endmodule // dtm_ctrl_sva

bind dtm_ctrl dtm_ctrl_sva #(
	.INTEG_CYCLES(INTEG_CYCLES),
	.BASE_PERIOD_CYCLES(BASE_PERIOD_CYCLES)
) u_sva (
	.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .RESET_PIN_I(RESET_PIN_I),
	.HW_STANDBY_N_I(HW_STANDBY_N_I), .OVERTEMP_ALARM_N_O(OVERTEMP_ALARM_N_O),
	.OVERTEMP_ALARM_N_OE_O(OVERTEMP_ALARM_N_OE_O), .ALERT_N_O(ALERT_N_O),
	.ALERT_N_OE_O(ALERT_N_OE_O), .ADC_CONV_O(ADC_CONV_O), .ADC_CHAN_O(ADC_CHAN_O),
	.SLAVE_ADDR_O(SLAVE_ADDR_O)
);

// File: sim/dtm_ctrl_tb.sv
// self-checking bench of the temperature monitor control block
`timescale 1ns/100ps
module dtm_ctrl_tb;
	localparam int BP = 8192; // shortened base period
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rpin = 1'b0;
	logic hw_standby_n_n = 1'b1;
	logic isel = 1'b1;
	logic [1:0] src = 2'h0;
	logic [1:0] saddr; // bus address the block latched from its pins
	logic [3:0] straps = 4'h0; // limit straps and address straps
	logic [10:0] adc = 11'h000;
	logic [5:0] a;
	logic rd, wr, wt, ovt_oe, al_oe, conv, chan, stype;
	logic [7:0] wd;
	logic [31:0] rdat, q;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 8;
	int loc_v = 0; // local temperature in eighths
	int rem_v = 0; // remote temperature in eighths
	always #5 clk = ~clk;
	// front end answers with the selected channel's temperature
	always @(posedge clk) adc <= chan ? 11'(rem_v) : 11'(loc_v);
	dtm_host u_host (.clk_i(clk), .wait_i(wt), .rdata_i(rdat), .addr_o(a), .rd_o(rd),
		.wr_o(wr), .wdata_o(wd));
	dtm_ctrl #(.INTEG_CYCLES(20), .BASE_PERIOD_CYCLES(BP)) u_dut (
		.CLK_SYS_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(a), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I({24'h000000, wd}), .AVS_BYTEENABLE_I(4'h1),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .RESET_PIN_I(rpin),
		.HW_STANDBY_N_I(hw_standby_n_n), .INT_SEL_I(isel), .ALARM_SOURCE_SELECT_I(src),
		.ADDR_SELECT_LO_I(straps[0]), .ADDR_SELECT_HI_I(straps[1]),
		.DEFAULT_LIMIT_STRAP_LO_I(straps[2]), .DEFAULT_LIMIT_STRAP_HI_I(straps[3]),
		.OVERTEMP_ALARM_N_O(), .OVERTEMP_ALARM_N_OE_O(ovt_oe), .ALERT_N_O(),
		.ALERT_N_OE_O(al_oe), .ADC_DATA_I(adc), .ADC_CONV_O(conv), .ADC_CHAN_O(chan),
		.ADC_SENSOR_TYPE_O(stype), .SLAVE_ADDR_O(saddr));
	// compare and count
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [5:0] ad, input logic [10:0] exp);
		u_host.xfer(1'b0, ad, 8'h00, q);
		chk(q[10:0], exp);
	endtask
	task automatic wr8(input logic [5:0] ad, input logic [7:0] d);
		u_host.xfer(1'b1, ad, d, q);
	endtask
	// alarm enable after the pin synchronisers settle
	task automatic oe_chk(input logic sel, input logic exp);
		repeat (6) @(posedge clk);
		chk({10'h000, sel ? al_oe : ovt_oe}, {10'h000, exp});
	endtask
	task automatic wait_conv(input logic lvl);
		while (conv !== lvl)
			@(posedge clk);
	endtask
	// one-shot sequence with given temperatures
	task automatic conv1(input int l, input int r);
		loc_v = l;
		rem_v = r;
		wr8(dtm_pkg::REG_ONESHOT, 8'h01);
		wait_conv(1'b1);
		wait_conv(1'b0);
	endtask
	// reference model: floor clamp, then format
	function automatic int clampv(input int v, input logic ext);
		return (v < (ext ? -512 : 0)) ? (ext ? -512 : 0) : v;
	endfunction
	function automatic logic [10:0] exp_rem(input int v, input logic ext, input logic fine);
		return fine ? 11'(clampv(v, ext)) : 11'(clampv(v, ext) & -8);
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog far beyond the expected run
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
	initial begin
		logic [7:0] cfg;
		logic [10:0] prev;
		longint t0;
		int n;
		straps <= 4'($random(seed));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(dtm_pkg::REG_CONFIG, 11'h000);
		rd_chk(dtm_pkg::REG_RATE, 11'h005);
		rd_chk(dtm_pkg::REG_LOC_HIGH, 11'h046);
		rd_chk(6'h34, 11'h000);
		// straps are latched by now: address and overtemp default follow them
		rd_chk(dtm_pkg::REG_ADDR, {9'h000, straps[1:0]});
		chk({9'h000, saddr}, {9'h000, straps[1:0]});
		rd_chk(dtm_pkg::REG_LOC_OVT,
			{3'h0, dtm_pkg::OVT_DEF_TABLE[{straps[3:2], 3'h0} +: 8]});
		wr8(dtm_pkg::REG_CONFIG, 8'h48);
		rpin <= 1'b1;
		repeat (6) @(posedge clk);
		rpin <= 1'b0;
		rd_chk(dtm_pkg::REG_CONFIG, 11'h000);
		wr8(dtm_pkg::REG_CONFIG, 8'h40);
		repeat (60) @(posedge clk);
		prev = 11'h000;
		// one-shots in software standby over resolution and range
		for (int i = 0; i < 4; i++) begin
			cfg = {2'b01, i[0], 1'b0, i[1], i[0], 2'b00};
			loc_v = ($random(seed) % 100) * 8;
			rem_v = $random(seed) % 800;
			wr8(dtm_pkg::REG_CONFIG, cfg);
			wr8(dtm_pkg::REG_ONESHOT, 8'h01);
			wait_conv(1'b1);
			rd_chk(dtm_pkg::REG_REM_TEMP, prev);
			u_host.xfer(1'b0, dtm_pkg::REG_STATUS, 8'h00, q);
			chk({10'h000, q[7]}, 11'h001);
			wait_conv(1'b0);
			prev = exp_rem(rem_v, cfg[3], cfg[2]);
			rd_chk(dtm_pkg::REG_LOC_TEMP, {3'h0, 8'(clampv(loc_v, cfg[3]) >>> 3)});
			rd_chk(dtm_pkg::REG_REM_TEMP, prev);
			chk({10'h000, stype}, {10'h000, cfg[5]});
		end
		// free-running: period and resolution per rate
		rem_v = 245;
		for (int r = 7; r > 5; r--) begin
			wr8(dtm_pkg::REG_RATE, 8'(r));
			wr8(dtm_pkg::REG_CONFIG, 8'h04);
			wait_conv(1'b0);
			wait_conv(1'b1);
			t0 = $time;
			wait_conv(1'b0);
			wait_conv(1'b1);
			chk(11'(($time - t0) / 10), 11'(BP >> r));
			wait_conv(1'b0);
			rd_chk(dtm_pkg::REG_REM_TEMP, exp_rem(rem_v, 1'b0, r < 7));
		end
		// hardware standby ignores one-shot, keeps registers
		hw_standby_n_n <= 1'b0;
		repeat (5) @(posedge clk);
		wr8(dtm_pkg::REG_ONESHOT, 8'h01);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			n += int'(conv);
		end
		chk(11'(n), 11'h000);
		rd_chk(dtm_pkg::REG_CONFIG, 11'h004);
		hw_standby_n_n <= 1'b1;
		wr8(dtm_pkg::REG_CONFIG, 8'h40);
		wr8(dtm_pkg::REG_LOC_OVT, 8'h32);
		wr8(dtm_pkg::REG_REM_OVT, 8'h64);
		repeat (60) @(posedge clk);
		u_host.xfer(1'b0, dtm_pkg::REG_STATUS, 8'h00, q);
		// overtemp source: local hot, then remote hot
		for (int j = 0; j < 2; j++) begin
			conv1(j ? 160 : 480, j ? 880 : 160);
			for (int s = 0; s < 4; s++) begin
				src <= 2'(s);
				oe_chk(1'b0, j ? s != 0 : s != 3);
			end
		end
		oe_chk(1'b1, 1'b1);
		u_host.xfer(1'b0, dtm_pkg::REG_STATUS, 8'h00, q);
		oe_chk(1'b1, 1'b0);
		isel <= 1'b0;
		oe_chk(1'b1, 1'b1);
		conv1(160, 160);
		oe_chk(1'b1, 1'b1);
		wr8(dtm_pkg::REG_CONFIG, 8'hC0);
		oe_chk(1'b1, 1'b0);
		conclude();
	end
endmodule // dtm_ctrl_tb

// File: sim/dtm_host.sv
// avalon-mm host model that plays software on the register port
`timescale 1ns/100ps
module dtm_host (
	input wire logic clk_i,
	input wire logic wait_i,
	input wire logic [31:0] rdata_i,
	output logic [5:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o
);
	// idle bus from time zero
	initial begin
		addr_o = 6'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	// one transfer, held until waitrequest low is sampled; one idle edge between requests
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= !w;
		wr_o <= w;
		wdata_o <= d;
		@(posedge clk_i);
		while (wait_i !== 1'b0)
			@(posedge clk_i);
		q = rdata_i;
		rd_o <= 1'b0;
		wr_o <= 1'b0;
	endtask
endmodule // dtm_host
